//--- fcs_seq.sv
// Function
// R1: Read mode needs no unlock cycles.
// R2: Query or error holds until reset command.
// R3: Host adds sectors within 80 us; the code's erase window is 100 us.
// R4: Query read gives 00h or 01h.
// R5: Suspend only during running sector erase.
// R6: Resume acts only when suspended.
// R7: Host runs code from the other bank.
// R8: Read mode at power-up, reset, reset command.
// R9: Host holds selects low, strobe high.
// R10: Plain reads return addressed array byte.
// R11: Program polling bit is data complement.
// R12: Status valid after fourth or sixth write.
// R13: Erase polling bit reads zero.
// R14: Program into protected sector is ignored.
// R15: All-protected erase holds zeros 100 us.
// R16: Toggle bit inverts on each status read.
// R17: Toggling stops, addressed byte returned.
// R18: Error bit set on program or erase failure.
// R19: Error bit cleared only by reset command.
// R20: Window bit zero during sector collection.
// R21: Status bits 7, 6, 5, 3 placed.
// R22: Host stops using a failed sector.
// R23: Commands open with two unlock writes.
// R24: Bad byte or gap returns read mode.
// R25: Only address bits 11 to 0 decoded.
// R26: New sector command restarts window.
// R27: Command byte codes decoded as listed.
`default_nettype none

module fcs_seq
  import fcs_pkg::*;
#(
  parameter logic [TMR_W-1:0] ERASE_WIN_CYCLES = ERASE_WIN_CYC,
  parameter logic [TMR_W-1:0] PROT_HOLD_CYCLES = PROT_HOLD_CYC,
  parameter logic [TMR_W-1:0] CMD_GAP_CYCLES = CMD_GAP_CYC
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [3:0] main_bank_sector_selects,
  input wire logic [1:0] second_bank_sector_selects,
  input wire logic write_strobe_line_n,
  input wire logic read_strobe_n,
  input wire logic [ADDR_W-1:0] bus_addr,
  input wire logic [DATA_W-1:0] bus_wdata,
  output logic [DATA_W-1:0] bus_rdata,
  input wire logic [SECT_N-1:0] sector_protected,
  output logic [ADDR_W-1:0] arr_addr,
  output logic [SECT_N-1:0] arr_sel,
  input wire logic [DATA_W-1:0] arr_rdata,
  output logic op_prog,
  output logic op_erase,
  output logic op_suspend,
  output logic op_resume,
  output logic op_abort,
  output logic [ADDR_W-1:0] op_addr,
  output logic [DATA_W-1:0] op_data,
  output logic [SECT_N-1:0] op_sectors,
  input wire logic op_done,
  input wire logic op_fail,
  output logic busy
);

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] pins_s;
  logic wr_s, rd_s, wr_prev_q, rd_prev_q, wev, rev;
  logic [SECT_N-1:0] sel_s, mask_q, mask_d;
  logic [ADDR_W-1:0] addr_s;
  logic [11:0] a12;
  logic [DATA_W-1:0] d_s, status_byte, rdata_q, op_data_q;
  logic [ADDR_W-1:0] op_addr_q;
  logic [SECT_N-1:0] op_sectors_q;
  fcs_state_t state_q, state_d, idle;
  logic bank_q, bank_d, susp_q, susp_d, err_q, err_set, err_clr;
  logic do_prog, do_erase, do_susp, do_resume, do_abort;
  logic op_prog_q, op_erase_q, op_susp_q, op_resume_q, op_abort_q;
  logic tmr_load, tmr_exp, last_prog_q, tog_q, toggling, status_rd;
  logic prefix, qaddr, prot_hit;
  logic [TMR_W-1:0] tmr_val;

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  function automatic logic cmd_at(input logic [11:0] a,
    input logic [7:0] d, input logic [7:0] c, input logic [11:0] ca);
    cmd_at = (d == c) && (a == ca);
  endfunction

  function automatic logic bank_of(input logic [SECT_N-1:0] s);
    bank_of = |(s & SECOND_SECTORS);
  endfunction

  function automatic logic [SECT_N-1:0] bank_sectors(input logic b);
    bank_sectors = b ? SECOND_SECTORS : MAIN_SECTORS;
  endfunction

  function automatic logic live(input logic [SECT_N-1:0] m,
    input logic [SECT_N-1:0] p);
    live = |(m & ~p);
  endfunction

  // ****************************************************************
  // Pin capture and strobe edges
  // ****************************************************************
  assign pins_raw = {write_strobe_line_n, read_strobe_n,
    second_bank_sector_selects, main_bank_sector_selects,
    bus_addr, bus_wdata};

  fcs_sync #(.W(PIN_W), .RST_VAL(PIN_RST)) u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .d(pins_raw),
    .q(pins_s)
  );

  assign wr_s = pins_s[PIN_WR];
  assign rd_s = pins_s[PIN_RD];
  assign sel_s = pins_s[PIN_SEL_LO +: SECT_N];
  assign addr_s = pins_s[PIN_ADDR_LO +: ADDR_W];
  assign d_s = pins_s[PIN_DATA_LO +: DATA_W];
  // R25: low address only.
  assign a12 = addr_s[11:0];
  assign prot_hit = |(sel_s & sector_protected);
  assign qaddr = ~addr_s[QA6] & addr_s[QA1] & ~addr_s[QA0];

  // R9: strobe idles high.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_prev_q <= 1'b1;
      rd_prev_q <= 1'b1;
    end
    else
    begin
      wr_prev_q <= wr_s;
      rd_prev_q <= rd_s;
    end
  end

  assign wev = wr_s & ~wr_prev_q & (|sel_s);
  assign rev = ~rd_s & rd_prev_q;

  fcs_timer u_timer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .load(tmr_load),
    .load_val(tmr_val),
    .expired(tmr_exp)
  );

  // ****************************************************************
  // Command decoder
  // ****************************************************************
  assign prefix = (state_q == ST_UNLK1) || (state_q == ST_UNLK2) ||
    (state_q == ST_PROG_DATA) || (state_q == ST_ERS_U0) ||
    (state_q == ST_ERS_U1) || (state_q == ST_ERS_U2);

  always_comb
  begin
    state_d = state_q;
    mask_d = mask_q;
    susp_d = susp_q;
    bank_d = bank_q;
    do_prog = 1'b0;
    do_erase = 1'b0;
    do_susp = 1'b0;
    do_resume = 1'b0;
    do_abort = 1'b0;
    tmr_load = 1'b0;
    tmr_val = CMD_GAP_CYCLES;
    err_set = 1'b0;
    err_clr = 1'b0;
    idle = susp_q ? ST_ERS_SUSP : ST_READ;
    // R24: gap time-out.
    if (prefix && tmr_exp)
      state_d = idle;
    case (state_q)
      ST_READ, ST_ERS_SUSP:
        if (wev)
        begin
          // R23: first unlock write.
          if (cmd_at(a12, d_s, CMD_UNLK1, UNLK1_ADDR))
          begin
            state_d = ST_UNLK1;
            bank_d = bank_of(sel_s);
            tmr_load = 1'b1;
          end
          // R6: resume only when suspended.
          else if (state_q == ST_ERS_SUSP && d_s == CMD_RESUME)
          begin
            state_d = ST_ERS_BUSY;
            susp_d = 1'b0;
            do_resume = 1'b1;
          end
          // R8: reset command.
          else if (d_s == CMD_RESET)
          begin
            state_d = ST_READ;
            susp_d = 1'b0;
            mask_d = '0;
            do_abort = susp_q;
          end
        end
      ST_UNLK1:
        if (wev)
        begin
          // R23: second unlock write.
          if (cmd_at(a12, d_s, CMD_UNLK2, UNLK2_ADDR))
          begin
            state_d = ST_UNLK2;
            tmr_load = 1'b1;
          end
          else
            state_d = idle;
        end
      ST_UNLK2:
        if (wev)
        begin
          tmr_load = 1'b1;
          // R27: command byte decode.
          if (cmd_at(a12, d_s, CMD_QUERY, UNLK1_ADDR))
            state_d = ST_QUERY;
          else if (cmd_at(a12, d_s, CMD_PROG, UNLK1_ADDR))
            state_d = ST_PROG_DATA;
          else if (cmd_at(a12, d_s, CMD_ERASE, UNLK1_ADDR) && !susp_q)
            state_d = ST_ERS_U0;
          else
            state_d = idle;
        end
      ST_PROG_DATA:
        if (wev)
        begin
          // R14: protected target ignored.
          if (prot_hit)
            state_d = idle;
          else
          begin
            state_d = ST_PROG_BUSY;
            do_prog = 1'b1;
          end
        end
      ST_ERS_U0:
        if (wev)
        begin
          state_d = cmd_at(a12, d_s, CMD_UNLK1, UNLK1_ADDR) ?
            ST_ERS_U1 : idle;
          tmr_load = 1'b1;
        end
      ST_ERS_U1:
        if (wev)
        begin
          state_d = cmd_at(a12, d_s, CMD_UNLK2, UNLK2_ADDR) ?
            ST_ERS_U2 : idle;
          tmr_load = 1'b1;
        end
      ST_ERS_U2:
        if (wev)
        begin
          if (d_s == CMD_SECT)
          begin
            state_d = ST_ERS_WIN;
            mask_d = sel_s;
            tmr_load = 1'b1;
            tmr_val = ERASE_WIN_CYCLES;
          end
          else if (cmd_at(a12, d_s, CMD_BULK, UNLK1_ADDR))
          begin
            mask_d = bank_sectors(bank_q);
            tmr_load = 1'b1;
            tmr_val = PROT_HOLD_CYCLES;
            state_d = ST_PROT_HOLD;
            if (live(bank_sectors(bank_q), sector_protected))
            begin
              state_d = ST_BULK_BUSY;
              do_erase = 1'b1;
            end
          end
          else
            state_d = idle;
        end
      ST_ERS_WIN:
        if (wev)
        begin
          // R26: extra sector restarts window.
          // R3: host keeps within the window.
          if (d_s == CMD_SECT)
          begin
            mask_d = mask_q | sel_s;
            tmr_load = 1'b1;
            tmr_val = ERASE_WIN_CYCLES;
          end
          else if (d_s != CMD_SUSPEND)
          begin
            state_d = ST_READ;
            mask_d = '0;
          end
        end
        else if (tmr_exp)
        begin
          // R15: all-protected erase holds.
          tmr_load = 1'b1;
          tmr_val = PROT_HOLD_CYCLES;
          state_d = ST_PROT_HOLD;
          if (live(mask_q, sector_protected))
          begin
            state_d = ST_ERS_BUSY;
            do_erase = 1'b1;
          end
        end
      ST_ERS_BUSY:
        // R18: failure sets error.
        if (op_fail)
        begin
          state_d = ST_ERROR;
          err_set = 1'b1;
        end
        else if (op_done)
        begin
          state_d = ST_READ;
          mask_d = '0;
        end
        // R5: suspend only while erasing.
        else if (wev && d_s == CMD_SUSPEND)
        begin
          state_d = ST_ERS_SUSP;
          susp_d = 1'b1;
          do_susp = 1'b1;
        end
        else if (wev && d_s == CMD_RESET)
        begin
          state_d = ST_READ;
          mask_d = '0;
          do_abort = 1'b1;
        end
      ST_PROG_BUSY, ST_BULK_BUSY:
        if (op_fail)
        begin
          state_d = ST_ERROR;
          err_set = 1'b1;
          susp_d = 1'b0;
          do_abort = susp_q;
        end
        else if (op_done)
          state_d = (state_q == ST_PROG_BUSY) ? idle : ST_READ;
      ST_PROT_HOLD:
        if (tmr_exp)
        begin
          state_d = ST_READ;
          mask_d = '0;
        end
      ST_QUERY, ST_ERROR:
        // R2: only reset leaves.
        if (wev && d_s == CMD_RESET)
        begin
          state_d = ST_READ;
          err_clr = 1'b1;
          susp_d = 1'b0;
          mask_d = '0;
          do_abort = susp_q;
        end
      default:
        state_d = ST_READ;
    endcase
  end

  // R8: power-up into read mode.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= ST_READ;
      mask_q <= '0;
      susp_q <= 1'b0;
      bank_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      mask_q <= mask_d;
      susp_q <= susp_d;
      bank_q <= bank_d;
    end
  end

  // R19: set wins, reset command clears.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      err_q <= 1'b0;
    else if (err_set)
      err_q <= 1'b1;
    else if (err_clr)
      err_q <= 1'b0;
  end

  // ****************************************************************
  // Array operation requests
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      op_prog_q <= 1'b0;
      op_erase_q <= 1'b0;
      op_susp_q <= 1'b0;
      op_resume_q <= 1'b0;
      op_abort_q <= 1'b0;
      op_addr_q <= '0;
      op_data_q <= '0;
      op_sectors_q <= '0;
      last_prog_q <= 1'b0;
    end
    else
    begin
      op_prog_q <= do_prog;
      op_erase_q <= do_erase;
      op_susp_q <= do_susp;
      op_resume_q <= do_resume;
      op_abort_q <= do_abort;
      if (do_prog)
      begin
        op_addr_q <= addr_s;
        op_data_q <= d_s;
        last_prog_q <= 1'b1;
      end
      if (do_erase)
        op_sectors_q <= mask_d & ~sector_protected;
      // R13: erase polling zero.
      if (state_d inside {ST_ERS_WIN, ST_ERS_BUSY, ST_BULK_BUSY,
        ST_PROT_HOLD})
        last_prog_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Read path and status
  // ****************************************************************
  assign toggling = (state_q == ST_PROG_BUSY) ||
    (state_q == ST_ERS_BUSY) || (state_q == ST_BULK_BUSY) ||
    (state_q == ST_ERS_WIN);
  // R7: status only for the busy bank.
  // R12: status after last command write.
  assign status_rd = (toggling || state_q == ST_PROT_HOLD ||
    state_q == ST_ERROR) && (|sel_s) && (bank_of(sel_s) == bank_q);

  // R21: status bit placement.
  always_comb
  begin
    status_byte = '0;
    // R11: program polling complement.
    // R13: erase polling zero.
    status_byte[POLL_BIT] = last_prog_q & ~op_data_q[7];
    status_byte[TOG_BIT] = toggling & tog_q;
    status_byte[ERR_BIT] = err_q;
    // R20: window bit low while collecting.
    status_byte[WIN_BIT] = (state_q != ST_ERS_WIN);
  end

  // R16: toggle per status read.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      tog_q <= 1'b0;
    else if (rev && status_rd && toggling)
      tog_q <= ~tog_q;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_q <= RDATA_RST;
    else if (rev)
    begin
      if (status_rd)
        rdata_q <= status_byte;
      // R4: protection query read.
      else if (state_q == ST_QUERY && qaddr && (|sel_s))
        rdata_q <= prot_hit ? PROT_YES : PROT_NO;
      // R1: plain array read.
      // R10: addressed array byte.
      // R17: back to array data.
      else
        rdata_q <= arr_rdata;
    end
  end

  assign bus_rdata = rdata_q;
  assign arr_addr = addr_s;
  assign arr_sel = sel_s;
  assign op_prog = op_prog_q;
  assign op_erase = op_erase_q;
  assign op_suspend = op_susp_q;
  assign op_resume = op_resume_q;
  assign op_abort = op_abort_q;
  assign op_addr = op_addr_q;
  assign op_data = op_data_q;
  assign op_sectors = op_sectors_q;
  assign busy = toggling || (state_q == ST_PROT_HOLD);

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_err_sticky: assert property (err_q && !err_clr |=> err_q) // R19
    else $error("error bit dropped without reset command");
  a_query_hold: assert property (state_q == ST_QUERY && !wev
    |=> state_q == ST_QUERY) // R2
    else $error("query mode left without a write");
  a_prot_query: assert property (rev && state_q == ST_QUERY && qaddr
    && (|sel_s) && !status_rd |=> rdata_q == {7'h00, $past(prot_hit)}) // R4
    else $error("wrong protection query data");
  a_prog_blocked: assert property (state_q == ST_PROG_DATA && wev
    && prot_hit |=> !op_prog_q ##1 !op_prog_q) // R14
    else $error("program issued to protected sector");
  a_suspend_only: assert property ($rose(op_suspend)
    |-> $past(state_q) == ST_ERS_BUSY) // R5
    else $error("suspend outside sector erase");
  a_resume_only: assert property (op_resume
    |-> $past(state_q) == ST_ERS_SUSP) // R6
    else $error("resume outside suspended state");
  a_poll_prog: assert property (rev && status_rd
    && state_q == ST_PROG_BUSY |=> rdata_q[7] == ~op_data_q[7]) // R11
    else $error("program polling bit not complemented");
  a_erase_poll: assert property (rev && status_rd
    && state_q == ST_ERS_BUSY |=> rdata_q[7] == 1'b0) // R13
    else $error("erase polling bit not zero");
  a_window_bit: assert property (rev && status_rd
    && state_q == ST_ERS_WIN |=> rdata_q[3] == 1'b0) // R20
    else $error("window bit set during collection");
  a_toggle_flip: assert property (rev && status_rd && toggling
    |=> tog_q != $past(tog_q)) // R16
    else $error("toggle bit did not invert");
  a_read_array: assert property (rev && state_q == ST_READ
    |=> rdata_q == $past(arr_rdata)) // R10
    else $error("read mode did not return array data");
  a_hold_zero: assert property (rev && status_rd
    && state_q == ST_PROT_HOLD |=> rdata_q[7:6] == 2'b00) // R15
    else $error("protected erase status not zero");

  c_program: cover property (op_prog ##[1:1000] state_q == ST_READ);
  c_suspend: cover property (op_suspend ##[1:1000] op_resume);
  c_query: cover property (state_q == ST_QUERY && rev);
  c_error: cover property (state_q == ST_ERROR ##[1:1000] !err_q);

endmodule

`default_nettype wire

//--- fcs_pkg.sv
`default_nettype none

package fcs_pkg;

  // ****************************************************************
  // Clock and times
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int ERASE_WIN_NS = 100000;
  localparam int PROT_HOLD_NS = 100000;
  localparam int CMD_GAP_NS = 80000;
  localparam int TMR_W = 16;
  localparam logic [TMR_W-1:0] ERASE_WIN_CYC =
    TMR_W'((ERASE_WIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] PROT_HOLD_CYC =
    TMR_W'((PROT_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] CMD_GAP_CYC =
    TMR_W'((CMD_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] TMR_ONE = 16'h0001;

  // ****************************************************************
  // Widths and pin vector layout
  // ****************************************************************
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int SECT_N = 6;
  localparam int PIN_W = 32;
  localparam int PIN_WR = 31;
  localparam int PIN_RD = 30;
  localparam int PIN_SEL_LO = 24;
  localparam int PIN_ADDR_LO = 8;
  localparam int PIN_DATA_LO = 0;
  localparam logic [PIN_W-1:0] PIN_RST = 32'hc000_0000;
  localparam logic [SECT_N-1:0] MAIN_SECTORS = 6'h0f;
  localparam logic [SECT_N-1:0] SECOND_SECTORS = 6'h30;

  // ****************************************************************
  // Command codes and addresses
  // ****************************************************************
  localparam logic [11:0] UNLK1_ADDR = 12'h555;
  localparam logic [11:0] UNLK2_ADDR = 12'haaa;
  localparam logic [7:0] CMD_UNLK1 = 8'haa;
  localparam logic [7:0] CMD_UNLK2 = 8'h55;
  localparam logic [7:0] CMD_QUERY = 8'h90;
  localparam logic [7:0] CMD_PROG = 8'ha0;
  localparam logic [7:0] CMD_ERASE = 8'h80;
  localparam logic [7:0] CMD_SECT = 8'h30;
  localparam logic [7:0] CMD_BULK = 8'h10;
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] CMD_RESUME = 8'h30;
  localparam logic [7:0] CMD_RESET = 8'hf0;

  // ****************************************************************
  // Status and query read layout
  // ****************************************************************
  localparam int POLL_BIT = 7;
  localparam int TOG_BIT = 6;
  localparam int ERR_BIT = 5;
  localparam int WIN_BIT = 3;
  localparam int QA6 = 6;
  localparam int QA1 = 1;
  localparam int QA0 = 0;
  localparam logic [7:0] PROT_NO = 8'h00;
  localparam logic [7:0] PROT_YES = 8'h01;
  localparam logic [7:0] RDATA_RST = 8'h00;

  typedef enum logic [3:0] {
    ST_READ, ST_UNLK1, ST_UNLK2, ST_PROG_DATA, ST_ERS_U0, ST_ERS_U1,
    ST_ERS_U2, ST_ERS_WIN, ST_ERS_BUSY, ST_ERS_SUSP, ST_BULK_BUSY,
    ST_PROG_BUSY, ST_PROT_HOLD, ST_QUERY, ST_ERROR
  } fcs_state_t;

endpackage

`default_nettype wire

//--- fcs_sync.sv
`default_nettype none

module fcs_sync
  import fcs_pkg::*;
#(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // ****************************************************************
  // Two flip-flop synchroniser
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end
    else
    begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;

endmodule

`default_nettype wire

//--- fcs_timer.sv
`default_nettype none

module fcs_timer
  import fcs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [TMR_W-1:0] load_val,
  output logic expired
);

  logic [TMR_W-1:0] count_q;

  // ****************************************************************
  // Down counter
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      count_q <= '0;
    else if (load)
      count_q <= load_val;
    else if (count_q != '0)
      count_q <= count_q - TMR_ONE;
  end

  assign expired = (count_q == TMR_ONE);

endmodule

`default_nettype wire

//--- fcs_array_model.sv
`default_nettype none

module fcs_array_model
  import fcs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] arr_addr,
  output logic [DATA_W-1:0] arr_rdata,
  input wire logic op_prog,
  input wire logic op_erase,
  input wire logic [ADDR_W-1:0] op_addr,
  input wire logic [DATA_W-1:0] op_data,
  input wire logic fail_next,
  output logic op_done,
  output logic op_fail
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Array contents and engine delay
  // ****************************************************************
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  int cnt_q;
  logic prog_q;
  assign arr_rdata = mem[arr_addr];
  initial
  begin
    foreach (mem[i]) mem[i] = 8'hff;
  end
  always @(posedge sys_clk or negedge rst_n)
  begin
    op_done <= 1'b0;
    op_fail <= 1'b0;
    if (!rst_n)
      cnt_q <= 0;
    else if (op_prog || op_erase)
    begin
      cnt_q <= 80;
      prog_q <= op_prog;
    end
    else if (cnt_q == 1)
    begin
      cnt_q <= 0;
      op_done <= 1'b1;
      op_fail <= fail_next;
      if (prog_q && !fail_next)
        mem[op_addr] <= mem[op_addr] & op_data;
    end
    else if (cnt_q > 1)
      cnt_q <= cnt_q - 1;
  end
endmodule

`default_nettype wire

//--- tb_flash_command_status_sequencer.sv
`default_nettype none

`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end

module tb_flash_command_status_sequencer
  import fcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, rst_n, write_strobe_line_n, read_strobe_n, busy;
  logic [3:0] main_bank_sector_selects;
  logic [1:0] second_bank_sector_selects;
  logic [15:0] bus_addr, arr_addr, op_addr, pa;
  logic [7:0] bus_wdata, bus_rdata, arr_rdata, op_data, pd, d, e;
  logic [5:0] sector_protected, sects;
  logic op_prog, op_erase, op_done, op_fail, fail_next;
  int fails, total_checks, seed;

  fcs_seq #(.ERASE_WIN_CYCLES(16'h0014), .PROT_HOLD_CYCLES(16'h0014),
    .CMD_GAP_CYCLES(16'h0028)) dut (.sys_clk, .rst_n,
    .main_bank_sector_selects, .second_bank_sector_selects,
    .write_strobe_line_n, .read_strobe_n, .bus_addr, .bus_wdata,
    .bus_rdata, .sector_protected, .arr_addr, .arr_sel(), .arr_rdata,
    .op_prog, .op_erase, .op_suspend(), .op_resume(), .op_abort(),
    .op_addr, .op_data, .op_sectors(sects), .op_done, .op_fail, .busy);
  fcs_array_model model (.sys_clk, .rst_n, .arr_addr, .arr_rdata,
    .op_prog, .op_erase, .op_addr, .op_data, .fail_next, .op_done,
    .op_fail);

  // ****************************************************************
  // Bus cycle tasks
  // ****************************************************************
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    bus_addr <= a;
    bus_wdata <= v;
    repeat (3) @(posedge sys_clk);
    write_strobe_line_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    write_strobe_line_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    bus_addr <= a;
    repeat (3) @(posedge sys_clk);
    read_strobe_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    v = bus_rdata;
    read_strobe_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic cmd(input logic [7:0] c);
    wr({4'($urandom), UNLK1_ADDR}, CMD_UNLK1);
    wr({4'($urandom), UNLK2_ADDR}, CMD_UNLK2);
    wr({4'($urandom), UNLK1_ADDR}, c);
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 500 && busy !== 1'b0; i++) @(posedge sys_clk);
    `CHK(busy, 1'b0)
  endtask
  function automatic logic [7:0] prog_result(input logic [7:0] old,
    input logic [7:0] v);
    prog_result = old & v;
  endfunction
  task automatic complete_run();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ****************************************************************
  // Clock, watchdog and tests
  // ****************************************************************
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  initial
  begin
    #200000;
    fails++;
    complete_run();
  end
  initial
  begin
    rst_n = 1'b0;
    main_bank_sector_selects = 4'h0;
    second_bank_sector_selects = 2'h0;
    write_strobe_line_n = 1'b1;
    read_strobe_n = 1'b1;
    bus_addr = 16'h0000;
    bus_wdata = 8'h00;
    sector_protected = 6'h02;
    fail_next = 1'b0;
    seed = $urandom(76);
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    main_bank_sector_selects <= 4'h1;
    pa = {4'h1, 12'($urandom)};
    pd = 8'($urandom);
    rd(pa, d);
    `CHK(d, 8'hff)
    $display("test plain read done");
    cmd(CMD_PROG);
    wr(pa, pd);
    rd(pa, d);
    `CHK(d[POLL_BIT], ~pd[7])
    rd(pa, e);
    `CHK(e[TOG_BIT], ~d[TOG_BIT])
    wait_idle();
    rd(pa, d);
    `CHK(d, prog_result(8'hff, pd))
    $display("test program done");
    main_bank_sector_selects <= 4'h2;
    cmd(CMD_PROG);
    wr(pa + 16'h0001, 8'h00);
    `CHK(busy, 1'b0)
    cmd(CMD_QUERY);
    rd(16'h0002, d);
    `CHK(d, PROT_YES)
    main_bank_sector_selects <= 4'h1;
    rd(16'h0002, d);
    `CHK(d, PROT_NO)
    wr(16'h0000, CMD_RESET);
    rd(pa, d);
    `CHK(d, pd)
    rd(pa + 16'h0001, d);
    `CHK(d, 8'hff)
    $display("test query done");
    fail_next <= 1'b1;
    cmd(CMD_PROG);
    wr(pa + 16'h0002, 8'h00);
    repeat (100) @(posedge sys_clk);
    rd(pa + 16'h0002, d);
    `CHK(d[ERR_BIT], 1'b1)
    rd(pa + 16'h0002, d);
    `CHK(d[ERR_BIT], 1'b1)
    fail_next <= 1'b0;
    wr(16'h0000, CMD_RESET);
    rd(pa + 16'h0002, d);
    `CHK(d, 8'hff)
    $display("test error done");
    main_bank_sector_selects <= 4'h2;
    cmd(CMD_ERASE);
    cmd(CMD_SECT);
    rd(pa, d);
    `CHK(d[WIN_BIT], 1'b0)
    repeat (5) @(posedge sys_clk);
    rd(pa, d);
    `CHK(d[7:6], 2'b00)
    repeat (40) @(posedge sys_clk);
    rd(pa, d);
    `CHK(d, prog_result(8'hff, pd))
    $display("test protected erase done");
    main_bank_sector_selects <= 4'h1;
    cmd(CMD_ERASE);
    cmd(CMD_SECT);
    main_bank_sector_selects <= 4'h4;
    wr(pa, CMD_SECT);
    repeat (10) @(posedge sys_clk);
    rd(pa, d);
    `CHK(d[WIN_BIT], 1'b0)
    rd(pa, d);
    `CHK(d[POLL_BIT], 1'b0)
    `CHK(d[WIN_BIT], 1'b1)
    `CHK(sects, 6'h05)
    wr(pa, CMD_SUSPEND);
    `CHK(busy, 1'b0)
    rd(pa, d);
    `CHK(d, prog_result(8'hff, pd))
    wr(pa, CMD_RESUME);
    `CHK(busy, 1'b1)
    wait_idle();
    $display("test sector erase done");
    complete_run();
  end
endmodule

`default_nettype wire
